/* File: lmi_pkg.sv */
`default_nettype none
package lmi_pkg;

  // Opcode patterns of the 14-bit instruction word
  localparam logic [13:0] OP_NOP       = 14'h0000;
  localparam logic [13:0] OP_SOFT_RST  = 14'h0001;
  localparam logic [13:0] OP_OPTION    = 14'h0062;
  localparam logic [13:0] MSK_LBL      = 14'h3FE0;
  localparam logic [13:0] PAT_LBL      = 14'h0020;
  localparam logic [13:0] MSK_LPL      = 14'h3F80;
  localparam logic [13:0] PAT_LPL      = 14'h3180;
  localparam logic [13:0] MSK_LWL      = 14'h3F00;
  localparam logic [13:0] PAT_LWL      = 14'h3000;
  localparam logic [13:0] MSK_SWF      = 14'h3F80;
  localparam logic [13:0] PAT_SWF      = 14'h0080;
  localparam logic [13:0] MSK_SWI      = 14'h3FF8;
  localparam logic [13:0] PAT_SWI      = 14'h0018;
  localparam logic [13:0] MSK_SWR      = 14'h3F80;
  localparam logic [13:0] PAT_SWR      = 14'h3F80;

  // Field positions inside the instruction word
  localparam int unsigned SWI_N_BIT    = 2;
  localparam int unsigned SWR_N_BIT    = 6;
  localparam int unsigned FILE_N_BIT   = 0;

  typedef enum logic [1:0] {
    MODE_PRE_INC  = 2'b00,
    MODE_PRE_DEC  = 2'b01,
    MODE_POST_INC = 2'b10,
    MODE_POST_DEC = 2'b11
  } lmi_mode_t;

  typedef enum logic [3:0] {
    I_NONE, I_NOP, I_LBL, I_LPL, I_LWL, I_SWF, I_SWI, I_SWR, I_OPT, I_RST
  } lmi_insn_t;

  // Wishbone byte offsets
  localparam logic [7:0] REG_WORK      = 8'h00;
  localparam logic [7:0] REG_BANK      = 8'h04;
  localparam logic [7:0] REG_PAGE      = 8'h08;
  localparam logic [7:0] REG_OPTION    = 8'h0C;
  localparam logic [7:0] REG_PTR0      = 8'h10;
  localparam logic [7:0] REG_PTR1      = 8'h14;
  localparam logic [7:0] REG_STATUS    = 8'h18;
  localparam logic [7:0] REG_POWER     = 8'h1C;
  localparam logic [7:0] REG_RETIRED   = 8'h20;
  localparam logic [7:0] REG_LAST_ADDR = 8'h24;

  // Core file addresses seen by the store-to-file instruction
  localparam logic [6:0] FA_IND0       = 7'h00;
  localparam logic [6:0] FA_IND1       = 7'h01;
  localparam logic [6:0] FA_STATUS     = 7'h03;
  localparam logic [6:0] FA_PTR0_LO    = 7'h04;
  localparam logic [6:0] FA_PTR0_HI    = 7'h05;
  localparam logic [6:0] FA_PTR1_LO    = 7'h06;
  localparam logic [6:0] FA_PTR1_HI    = 7'h07;
  localparam logic [6:0] FA_BANK       = 7'h08;
  localparam logic [6:0] FA_WORK       = 7'h09;
  localparam logic [6:0] FA_PAGE       = 7'h0A;

  // Reset values and bit positions
  localparam logic [7:0]  RST_WORK     = 8'h00;
  localparam logic [4:0]  RST_BANK     = 5'h00;
  localparam logic [6:0]  RST_PAGE     = 7'h00;
  localparam logic [7:0]  RST_OPTION   = 8'hFF;
  localparam logic [15:0] RST_PTR      = 16'h0000;
  localparam logic [2:0]  RST_STATUS   = 3'h0;
  localparam logic        RST_RI       = 1'b1;
  localparam int unsigned POWER_CONTROL_REG_RI_BIT  = 2;

endpackage : lmi_pkg
`default_nettype wire

/* File: lmi_ptr_unit.sv */
`timescale 1ns/1ns
`default_nettype none
module lmi_ptr_unit (
  // Pointer and addressing form
  input  wire logic [15:0]        ptr,
  input  wire lmi_pkg::lmi_mode_t mode,
  input  wire logic               relative,
  input  wire logic [5:0]         offset,
  // Results
  output logic      [15:0]        eff_addr,
  output logic      [15:0]        ptr_next
);

  logic [15:0] ptr_inc;
  logic [15:0] ptr_dec;
  logic [15:0] ptr_rel;

  // Plain 16-bit arithmetic gives the wrap at both ends
  assign ptr_inc = ptr + 16'h0001;
  assign ptr_dec = ptr - 16'h0001;
  assign ptr_rel = ptr + {{10{offset[5]}}, offset};

  always_comb
  begin
    eff_addr = ptr;
    ptr_next = ptr;
    if (relative)
    begin
      eff_addr = ptr_rel;
    end
    else
    begin
      case (mode)
        lmi_pkg::MODE_PRE_INC:
        begin
          eff_addr = ptr_inc;
          ptr_next = ptr_inc;
        end
        lmi_pkg::MODE_PRE_DEC:
        begin
          eff_addr = ptr_dec;
          ptr_next = ptr_dec;
        end
        lmi_pkg::MODE_POST_INC:
        begin
          ptr_next = ptr_inc;
        end
        default:
        begin
          ptr_next = ptr_dec;
        end
      endcase
    end
  end

endmodule : lmi_ptr_unit
`default_nettype wire

/* File: lmi_wb_slave.sv */
`timescale 1ns/1ns
`default_nettype none
module lmi_wb_slave (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Wishbone request
  input  wire logic        cyc,
  input  wire logic        stb,
  input  wire logic        we,
  input  wire logic [31:0] rd_word,
  // Answer
  output logic             ack,
  output logic      [31:0] dat_o,
  output logic             wr_fire
);

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } lmi_wb_state_t;

  lmi_wb_state_t s_q;
  lmi_wb_state_t s_d;

  // Ack one cycle after the request; dropping it next cycle keeps one ack per access
  always_comb
  begin
    s_d = s_q;
    s_d.ack = cyc & stb & ~s_q.ack;
    if (cyc && stb && !s_q.ack)
    begin
      s_d.dat = rd_word;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign ack     = s_q.ack;
  assign dat_o   = s_q.dat;
  // Writes land on the edge where the master sees ack
  assign wr_fire = cyc & stb & we & s_q.ack;

endmodule : lmi_wb_slave
`default_nettype wire

/* File: lmi_exec_core.sv */
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module lmi_exec_core (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Instruction stream
  input  wire logic        INSN_VALID,
  input  wire logic [13:0] INSN_WORD,
  output logic             INSN_READY,
  // Data memory write port
  output logic             MEM_WE,
  output logic      [15:0] MEM_ADDR,
  output logic      [7:0]  MEM_WDATA,
  // Core state
  output logic      [7:0]  WORK_REG,
  output logic      [4:0]  BANK_SELECT_REG,
  output logic      [6:0]  PC_LATCH_HIGH,
  output logic      [7:0]  OPTION_CFG,
  output logic             SOFT_RESET,
  output logic             RETIRE
);

  typedef struct packed {
    logic [7:0]  work_reg;
    logic [4:0]  bank_select_reg;
    logic [6:0]  pc_latch_high;
    logic [7:0]  option_cfg;
    logic [15:0] indirect_pointer0;
    logic [15:0] indirect_pointer1;
    logic [2:0]  status;
    logic        reset_instruction_flag;
    logic        mem_we;
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic        soft_rst;
    logic        retire;
    logic [15:0] retired;
    logic [15:0] last_addr;
  } lmi_core_state_t;

  localparam lmi_core_state_t RST_STATE = '{
    work_reg:               lmi_pkg::RST_WORK,
    bank_select_reg:        lmi_pkg::RST_BANK,
    pc_latch_high:          lmi_pkg::RST_PAGE,
    option_cfg:             lmi_pkg::RST_OPTION,
    indirect_pointer0:      lmi_pkg::RST_PTR,
    indirect_pointer1:      lmi_pkg::RST_PTR,
    status:                 lmi_pkg::RST_STATUS,
    reset_instruction_flag: lmi_pkg::RST_RI,
    mem_we:                 1'b0,
    mem_addr:               16'h0000,
    mem_wdata:              8'h00,
    soft_rst:               1'b0,
    retire:                 1'b0,
    retired:                16'h0000,
    last_addr:              16'h0000
  };

  lmi_core_state_t    st_q;
  lmi_core_state_t    st_d;
  lmi_pkg::lmi_insn_t insn_kind;
  logic               insn_take;
  logic               ptr_sel;
  logic [15:0]        ptr_cur;
  lmi_pkg::lmi_mode_t ptr_mode;
  logic               ptr_relative;
  logic [5:0]         ptr_offset;
  logic [15:0]        eff_addr;
  logic [15:0]        ptr_next;
  logic [6:0]         file_addr;
  logic [7:0]         wb_word;
  logic [31:0]        rd_word;
  logic               wr_fire;

  function automatic lmi_pkg::lmi_insn_t decode(input logic [13:0] iw);
    if (iw == lmi_pkg::OP_NOP)
      decode = lmi_pkg::I_NOP;
    else if (iw == lmi_pkg::OP_SOFT_RST)
      decode = lmi_pkg::I_RST;
    else if (iw == lmi_pkg::OP_OPTION)
      decode = lmi_pkg::I_OPT;
    else if ((iw & lmi_pkg::MSK_LBL) == lmi_pkg::PAT_LBL)
      decode = lmi_pkg::I_LBL;
    else if ((iw & lmi_pkg::MSK_LPL) == lmi_pkg::PAT_LPL)
      decode = lmi_pkg::I_LPL;
    else if ((iw & lmi_pkg::MSK_LWL) == lmi_pkg::PAT_LWL)
      decode = lmi_pkg::I_LWL;
    else if ((iw & lmi_pkg::MSK_SWF) == lmi_pkg::PAT_SWF)
      decode = lmi_pkg::I_SWF;
    else if ((iw & lmi_pkg::MSK_SWI) == lmi_pkg::PAT_SWI)
      decode = lmi_pkg::I_SWI;
    else if ((iw & lmi_pkg::MSK_SWR) == lmi_pkg::PAT_SWR)
      decode = lmi_pkg::I_SWR;
    else
      decode = lmi_pkg::I_NONE;
  endfunction : decode

  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] dat,
    input logic [3:0]  sel
  );
    merge16 = old;
    if (sel[0])
      merge16[7:0] = dat[7:0];
    if (sel[1])
      merge16[15:8] = dat[15:8];
  endfunction : merge16

  // Instruction words come from logic on this clock, so no synchroniser
  assign insn_kind = decode(INSN_WORD);
  // Nothing is taken during the reset pulse the core itself raised
  assign INSN_READY = ~st_q.soft_rst;
  assign insn_take  = INSN_VALID & ~st_q.soft_rst;
  assign file_addr  = INSN_WORD[6:0];
  assign wb_word    = {WB_ADR_I[7:2], 2'b00};

  // One adder set serves all three pointer forms
  always_comb
  begin
    ptr_sel      = INSN_WORD[lmi_pkg::FILE_N_BIT];
    ptr_relative = 1'b1;
    ptr_offset   = 6'h00;
    ptr_mode     = lmi_pkg::lmi_mode_t'(INSN_WORD[1:0]);
    if (insn_kind == lmi_pkg::I_SWI)
    begin
      ptr_sel      = INSN_WORD[lmi_pkg::SWI_N_BIT];
      ptr_relative = 1'b0;
    end
    else if (insn_kind == lmi_pkg::I_SWR)
    begin
      ptr_sel    = INSN_WORD[lmi_pkg::SWR_N_BIT];
      ptr_offset = INSN_WORD[5:0];
    end
    ptr_cur = ptr_sel ? st_q.indirect_pointer1 : st_q.indirect_pointer0;
  end

  lmi_ptr_unit u_ptr (
    .ptr      (ptr_cur),
    .mode     (ptr_mode),
    .relative (ptr_relative),
    .offset   (ptr_offset),
    .eff_addr (eff_addr),
    .ptr_next (ptr_next)
  );

  lmi_wb_slave u_wb (
    .clk     (CLK),
    .rst_b   (RST_B),
    .cyc     (WB_CYC_I),
    .stb     (WB_STB_I),
    .we      (WB_WE_I),
    .rd_word (rd_word),
    .ack     (WB_ACK_O),
    .dat_o   (WB_DAT_O),
    .wr_fire (wr_fire)
  );

  // Unmapped offsets read zero and still get an ack
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (wb_word == lmi_pkg::REG_WORK)
      rd_word[7:0] = st_q.work_reg;
    else if (wb_word == lmi_pkg::REG_BANK)
      rd_word[4:0] = st_q.bank_select_reg;
    else if (wb_word == lmi_pkg::REG_PAGE)
      rd_word[6:0] = st_q.pc_latch_high;
    else if (wb_word == lmi_pkg::REG_OPTION)
      rd_word[7:0] = st_q.option_cfg;
    else if (wb_word == lmi_pkg::REG_PTR0)
      rd_word[15:0] = st_q.indirect_pointer0;
    else if (wb_word == lmi_pkg::REG_PTR1)
      rd_word[15:0] = st_q.indirect_pointer1;
    else if (wb_word == lmi_pkg::REG_STATUS)
      rd_word[2:0] = st_q.status;
    else if (wb_word == lmi_pkg::REG_POWER)
      rd_word[lmi_pkg::POWER_CONTROL_REG_RI_BIT] = st_q.reset_instruction_flag;
    else if (wb_word == lmi_pkg::REG_RETIRED)
      rd_word[15:0] = st_q.retired;
    else if (wb_word == lmi_pkg::REG_LAST_ADDR)
      rd_word[15:0] = st_q.last_addr;
  end

  always_comb
  begin
    st_d = st_q;
    st_d.mem_we   = 1'b0;
    st_d.soft_rst = 1'b0;
    st_d.retire   = 1'b0;

    // Bus writes first; an instruction in the same cycle overrides them
    if (wr_fire)
    begin
      if (wb_word == lmi_pkg::REG_WORK)
      begin
        if (WB_SEL_I[0])
          st_d.work_reg = WB_DAT_I[7:0];
      end
      else if (wb_word == lmi_pkg::REG_BANK)
      begin
        if (WB_SEL_I[0])
          st_d.bank_select_reg = WB_DAT_I[4:0];
      end
      else if (wb_word == lmi_pkg::REG_PAGE)
      begin
        if (WB_SEL_I[0])
          st_d.pc_latch_high = WB_DAT_I[6:0];
      end
      else if (wb_word == lmi_pkg::REG_OPTION)
      begin
        if (WB_SEL_I[0])
          st_d.option_cfg = WB_DAT_I[7:0];
      end
      else if (wb_word == lmi_pkg::REG_PTR0)
      begin
        st_d.indirect_pointer0 = merge16(st_q.indirect_pointer0, WB_DAT_I, WB_SEL_I);
      end
      else if (wb_word == lmi_pkg::REG_PTR1)
      begin
        st_d.indirect_pointer1 = merge16(st_q.indirect_pointer1, WB_DAT_I, WB_SEL_I);
      end
      else if (wb_word == lmi_pkg::REG_STATUS)
      begin
        if (WB_SEL_I[0])
          st_d.status = WB_DAT_I[2:0];
      end
      else if (wb_word == lmi_pkg::REG_POWER)
      begin
        if (WB_SEL_I[0])
          st_d.reset_instruction_flag = WB_DAT_I[lmi_pkg::POWER_CONTROL_REG_RI_BIT];
      end
    end

    // Status is written below only as an addressed file register or by the soft reset
    if (insn_take)
    begin
      case (insn_kind)
        lmi_pkg::I_NOP:
        begin
          st_d.retire = 1'b1;
        end
        lmi_pkg::I_LBL:
        begin
          st_d.bank_select_reg = INSN_WORD[4:0];
          st_d.retire = 1'b1;
        end
        lmi_pkg::I_LPL:
        begin
          st_d.pc_latch_high = INSN_WORD[6:0];
          st_d.retire = 1'b1;
        end
        lmi_pkg::I_LWL:
        begin
          st_d.work_reg = INSN_WORD[7:0];
          st_d.retire = 1'b1;
        end
        lmi_pkg::I_OPT:
        begin
          st_d.option_cfg = st_q.work_reg;
          st_d.retire = 1'b1;
        end
        lmi_pkg::I_SWF:
        begin
          st_d.retire = 1'b1;
          if (file_addr == lmi_pkg::FA_IND0 || file_addr == lmi_pkg::FA_IND1)
          begin
            st_d.mem_we    = 1'b1;
            st_d.mem_addr  = eff_addr;
            st_d.mem_wdata = st_q.work_reg;
          end
          else if (file_addr == lmi_pkg::FA_STATUS)
            st_d.status = st_q.work_reg[2:0];
          else if (file_addr == lmi_pkg::FA_PTR0_LO)
            st_d.indirect_pointer0[7:0] = st_q.work_reg;
          else if (file_addr == lmi_pkg::FA_PTR0_HI)
            st_d.indirect_pointer0[15:8] = st_q.work_reg;
          else if (file_addr == lmi_pkg::FA_PTR1_LO)
            st_d.indirect_pointer1[7:0] = st_q.work_reg;
          else if (file_addr == lmi_pkg::FA_PTR1_HI)
            st_d.indirect_pointer1[15:8] = st_q.work_reg;
          else if (file_addr == lmi_pkg::FA_BANK)
            st_d.bank_select_reg = st_q.work_reg[4:0];
          else if (file_addr == lmi_pkg::FA_WORK)
            st_d.work_reg = st_q.work_reg;
          else if (file_addr == lmi_pkg::FA_PAGE)
            st_d.pc_latch_high = st_q.work_reg[6:0];
          else
          begin
            st_d.mem_we    = 1'b1;
            st_d.mem_addr  = {4'h0, st_q.bank_select_reg, file_addr};
            st_d.mem_wdata = st_q.work_reg;
          end
        end
        lmi_pkg::I_SWI, lmi_pkg::I_SWR:
        begin
          st_d.retire    = 1'b1;
          st_d.mem_we    = 1'b1;
          st_d.mem_addr  = eff_addr;
          st_d.mem_wdata = st_q.work_reg;
          // Only the pointer is written, and only SWI moves it (SWR writes it back unchanged); status stays as it was
          if (ptr_sel)
            st_d.indirect_pointer1 = ptr_next;
          else
            st_d.indirect_pointer0 = ptr_next;
        end
        lmi_pkg::I_RST:
        begin
          st_d = RST_STATE;
          st_d.reset_instruction_flag = 1'b0;
          st_d.soft_rst  = 1'b1;
          st_d.retire    = 1'b1;
          st_d.retired   = st_q.retired;
          st_d.last_addr = st_q.last_addr;
        end
        default:
        begin
          // Other instructions belong to other units
          st_d.retire = 1'b0;
        end
      endcase
    end

    if (st_d.mem_we)
      st_d.last_addr = st_d.mem_addr;
    // Counter wraps; software reads it only as a progress indication
    if (st_d.retire)
      st_d.retired = st_q.retired + 16'h0001;
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      st_q <= RST_STATE;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign MEM_WE          = st_q.mem_we;
  assign MEM_ADDR        = st_q.mem_addr;
  assign MEM_WDATA       = st_q.mem_wdata;
  assign WORK_REG        = st_q.work_reg;
  assign BANK_SELECT_REG = st_q.bank_select_reg;
  assign PC_LATCH_HIGH   = st_q.pc_latch_high;
  assign OPTION_CFG      = st_q.option_cfg;
  assign SOFT_RESET      = st_q.soft_rst;
  assign RETIRE          = st_q.retire;

endmodule : lmi_exec_core
`default_nettype wire

/* File: lmi_exec_core_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module lmi_exec_core_asserts (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST_B,
  // Instruction stream
  input wire logic        INSN_VALID,
  input wire logic [13:0] INSN_WORD,
  input wire logic        INSN_READY,
  // Results
  input wire logic        MEM_WE,
  input wire logic [15:0] MEM_ADDR,
  input wire logic [7:0]  MEM_WDATA,
  input wire logic [7:0]  WORK_REG,
  input wire logic [4:0]  BANK_SELECT_REG,
  input wire logic [6:0]  PC_LATCH_HIGH,
  input wire logic [7:0]  OPTION_CFG,
  input wire logic        SOFT_RESET,
  input wire logic        RETIRE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  sequence hit_s(logic [13:0] m, logic [13:0] v);
    INSN_VALID && INSN_READY && (INSN_WORD & m) == v;
  endsequence
  sequence done_s;
    RETIRE && !MEM_WE;
  endsequence
  // Registers are only required back at reset once the pulse has passed
  sequence rst_s;
    SOFT_RESET && !INSN_READY ##1 !SOFT_RESET && WORK_REG == lmi_pkg::RST_WORK
      && OPTION_CFG == lmi_pkg::RST_OPTION;
  endsequence

  bank_load_a: assert property (hit_s(lmi_pkg::MSK_LBL, lmi_pkg::PAT_LBL) |=> done_s
    and BANK_SELECT_REG == $past(INSN_WORD[4:0])) else $error("bank not loaded");
  page_load_a: assert property (hit_s(lmi_pkg::MSK_LPL, lmi_pkg::PAT_LPL) |=> done_s
    and PC_LATCH_HIGH == $past(INSN_WORD[6:0])) else $error("page not loaded");
  work_load_a: assert property (hit_s(lmi_pkg::MSK_LWL, lmi_pkg::PAT_LWL) |=> done_s
    and WORK_REG == $past(INSN_WORD[7:0])) else $error("work not loaded");
  file_store_a: assert property (hit_s(lmi_pkg::MSK_SWF, lmi_pkg::PAT_SWF)
    ##0 INSN_WORD[6:0] > lmi_pkg::FA_PAGE |=> MEM_WE && MEM_WDATA == $past(WORK_REG)
    && MEM_ADDR == {4'h0, $past(BANK_SELECT_REG), $past(INSN_WORD[6:0])})
    else $error("file store wrong");
  ind_store_a: assert property (hit_s(lmi_pkg::MSK_SWI, lmi_pkg::PAT_SWI) |=> MEM_WE
    && RETIRE && MEM_WDATA == $past(WORK_REG) && $stable(WORK_REG))
    else $error("indirect store wrong");
  opt_load_a: assert property (hit_s(14'h3FFF, lmi_pkg::OP_OPTION) |=> done_s
    and OPTION_CFG == $past(WORK_REG)) else $error("option not loaded");
  nop_keep_a: assert property (hit_s(14'h3FFF, lmi_pkg::OP_NOP) |=> done_s
    and $stable(WORK_REG) && $stable(BANK_SELECT_REG) && $stable(PC_LATCH_HIGH)
    && $stable(OPTION_CFG)) else $error("nop changed state");
  soft_rst_a: assert property (hit_s(14'h3FFF, lmi_pkg::OP_SOFT_RST) |=> rst_s)
    else $error("soft reset wrong");
endmodule : lmi_exec_core_asserts

bind lmi_exec_core lmi_exec_core_asserts u_chk (.CLK(CLK), .RST_B(RST_B),
  .INSN_VALID(INSN_VALID), .INSN_WORD(INSN_WORD), .INSN_READY(INSN_READY),
  .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .WORK_REG(WORK_REG),
  .BANK_SELECT_REG(BANK_SELECT_REG), .PC_LATCH_HIGH(PC_LATCH_HIGH),
  .OPTION_CFG(OPTION_CFG), .SOFT_RESET(SOFT_RESET), .RETIRE(RETIRE));
`default_nettype wire

/* File: lmi_prog_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module lmi_prog_mem (
  // Clock
  input  wire logic       clk,
  // Fetch handshake
  input  wire logic       ready,
  output var logic        valid,
  output var logic [13:0] word
);
  initial
  begin
    valid = 1'b0;
    word = 14'h0000;
  end
  // Idle cycles flip the word so a stale opcode never looks fresh
  task automatic idle();
    valid <= 1'b0;
    word <= ~word;
    @(posedge clk);
  endtask : idle
  // Entered and left just after a rising edge; word held until taken
  task automatic issue(input logic [13:0] w, input int gap);
    repeat (gap) idle();
    valid <= 1'b1;
    word <= w;
    // Ready comes from registers, so its value before the edge is what the core saw
    do @(posedge clk); while (ready !== 1'b1);
  endtask : issue
endmodule : lmi_prog_mem
`default_nettype wire

/* File: literal_move_indirect_exec_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module literal_move_indirect_exec_tb;
  logic        clk;
  logic        rst_b;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack;
  logic        i_valid;
  logic [13:0] i_word;
  logic        i_ready;
  logic        mem_we;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic [31:0] q[$];
  logic [31:0] exp_v;
  logic [15:0] p;
  logic [15:0] np;
  logic [15:0] ea;
  logic [7:0]  k;
  logic [7:0]  w;
  logic [7:0]  pa;
  logic [6:0]  f;
  logic [5:0]  o;
  int          fails;
  int          cmp_count;

  lmi_exec_core DUT (.CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .INSN_VALID(i_valid), .INSN_WORD(i_word), .INSN_READY(i_ready),
    .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .WORK_REG(),
    .BANK_SELECT_REG(), .PC_LATCH_HIGH(), .OPTION_CFG(), .SOFT_RESET(), .RETIRE());
  lmi_prog_mem PM (.clk(clk), .ready(i_ready), .valid(i_valid), .word(i_word));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic end_of_test();
    if (q.size() != 0)
      fails++;
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    dat_i <= d;
    // Only the watchdog ends a wait for the answer
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    q.push_back(x);
    wb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Random fetch gaps make the memory answer slowly as well as promptly
  task automatic ex(input logic [13:0] iw);
    PM.issue(iw, $urandom % 3);
    PM.idle();
  endtask : ex

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end

  // Sampled at the rising edge, before the core updates, as the core itself sees them
  always @(posedge clk)
  begin
    if (mem_we === 1'b1 || (ack === 1'b1 && we === 1'b0))
    begin
      exp_v = (q.size() != 0) ? q.pop_front() : 32'hXXXX_XXXX;
      chk(mem_we === 1'b1 ? {8'h00, mem_addr, mem_wdata} : dat_o, exp_v);
    end
  end

  initial
  begin
    rst_b = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat_i = 32'h0000_0000;
    fails = 0;
    cmp_count = 0;
    void'($urandom(51));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(lmi_pkg::REG_OPTION, 32'h0000_00FF);
    rd(lmi_pkg::REG_POWER, 32'h0000_0004);
    wb(1'b1, 8'h30, 32'hFFFF_FFFF);
    rd(8'h30, 32'h0000_0000);
    wb(1'b1, lmi_pkg::REG_STATUS, 32'h0000_0005);
    for (int i = 0; i < 3; i++)
    begin
      k = (i == 0) ? 8'hFF : 8'($urandom);
      w = k;
      ex(lmi_pkg::PAT_LBL | {9'h000, k[4:0]});
      PM.issue(lmi_pkg::PAT_LPL | {7'h00, k[6:0]}, 0);
      PM.issue(lmi_pkg::PAT_LWL | {6'h00, k}, 0);
      ex(lmi_pkg::OP_OPTION);
      rd(lmi_pkg::REG_BANK, {27'h0, k[4:0]});
      rd(lmi_pkg::REG_PAGE, {25'h0, k[6:0]});
      rd(lmi_pkg::REG_WORK, {24'h0, k});
      rd(lmi_pkg::REG_OPTION, {24'h0, k});
      f = (i == 0) ? 7'h7F : 7'(7'h0B + $urandom % 117);
      q.push_back({12'h000, k[4:0], f, k});
      ex(lmi_pkg::PAT_SWF | {7'h00, f});
    end
    // Fixed pointers sit at the wrap edges, random ones anywhere
    for (int r = 0; r < 2; r++)
      for (int n = 0; n < 2; n++)
        for (int m = 0; m < 4; m++)
        begin
          p = (r != 0) ? 16'($urandom) : (m[0] ? 16'h0000 : 16'hFFFF);
          pa = lmi_pkg::REG_PTR0 + 8'(4 * n);
          np = m[0] ? p - 16'h1 : p + 16'h1;
          ea = m[1] ? p : np;
          wb(1'b1, pa, {16'h0000, p});
          q.push_back({8'h00, ea, w});
          ex(lmi_pkg::PAT_SWI | {11'h000, n[0], m[1:0]});
          rd(pa, {16'h0000, np});
        end
    p = 16'($urandom);
    wb(1'b1, lmi_pkg::REG_PTR0, {16'h0000, p});
    q.push_back({8'h00, p, w});
    q.push_back({8'h00, p + 16'h1, w});
    PM.issue(lmi_pkg::PAT_SWI | 14'h0002, 0);
    ex(lmi_pkg::PAT_SWI | 14'h0002);
    rd(lmi_pkg::REG_PTR0, {16'h0000, p + 16'h2});
    rd(lmi_pkg::REG_STATUS, 32'h0000_0005);
    for (int j = 0; j < 2; j++)
    begin
      o = (j != 0) ? 6'h1F : 6'h20;
      p = 16'($urandom);
      wb(1'b1, lmi_pkg::REG_PTR1, {16'h0000, p});
      q.push_back({8'h00, p + {{10{o[5]}}, o}, w});
      ex(lmi_pkg::PAT_SWR | {7'h00, 1'b1, o});
      rd(lmi_pkg::REG_PTR1, {16'h0000, p});
    end
    q.push_back({8'h00, p, w});
    ex(lmi_pkg::PAT_SWF | {7'h00, lmi_pkg::FA_IND1});
    rd(lmi_pkg::REG_PTR1, {16'h0000, p});
    ex(lmi_pkg::PAT_SWF | {7'h00, lmi_pkg::FA_PTR1_HI});
    rd(lmi_pkg::REG_PTR1, {16'h0000, w, p[7:0]});
    ex(lmi_pkg::PAT_SWF | {7'h00, lmi_pkg::FA_STATUS});
    rd(lmi_pkg::REG_STATUS, {29'h0, w[2:0]});
    PM.issue(lmi_pkg::OP_NOP, 0);
    ex(lmi_pkg::OP_NOP);
    rd(lmi_pkg::REG_WORK, {24'h0, w});
    ex(lmi_pkg::OP_SOFT_RST);
    rd(lmi_pkg::REG_POWER, 32'h0000_0000);
    rd(lmi_pkg::REG_WORK, 32'h0000_0000);
    rd(lmi_pkg::REG_OPTION, 32'h0000_00FF);
    end_of_test();
  end
endmodule : literal_move_indirect_exec_tb
`default_nettype wire
